// ==== hw/lpddr2_init_and_mode_registers.sv ====
// bring-up sequencing and mode register file of the memory device
//
// How it works
// - device sits idle after auto-init completes and accepts any command
// - auto-initialization finishes within 10 us of the reset write
// - outputs stay undriven while clock enable is low
// - registers read by read command, written by write command, per access class
// - reserved bits of readable registers read as zero
// - write-only and reserved registers return filler data with normal strobe
// - writes to read-only registers change nothing
// - vendor address ranges behave as reserved
// - first calibration pattern readable at 0x20
// - second calibration pattern readable at 0x28
// - pending bit 0 of register 0x00 clears when auto-init ends
module lpddr2_init_and_mode_registers (
   input  wire logic                        clk_sys_i,
   input  wire logic                        rstn_i,
   input  wire logic                        ck_mem_i,
   input  wire logic                        cke_i,
   input  wire logic                        cmd_mrw_i,
   input  wire logic                        cmd_mrr_i,
   input  wire logic [7:0]                  ma_i,
   input  wire logic [7:0]                  op_i,
   output logic      [7:0]                  dq_o,
   output logic                             dq_oe_o,
   output logic                             dqs_o,
   output logic                             dqs_oe_o,
   output logic                             rd_valid_o,
   output logic                             idle_o,
   output logic                             auto_init_pending_o,
   output logic      [7:0]                  feature_one_o,
   output logic      [7:0]                  feature_two_o,
   output logic      [7:0]                  io_config_o,
   output logic      [7:0]                  bank_mask_o,
   output lpddr2_init_pkg::dev_state_t      state_o
);
   import lpddr2_init_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // link domain: command decode

   dev_state_t       state_r;
   dev_state_t       state_nxt;
   logic [7:0]       feature_one_r;
   logic [7:0]       feature_two_r;
   logic [7:0]       io_config_r;
   logic [7:0]       bank_mask_r;
   logic [1:0]       selftest_r;
   logic             reset_tgl_r;
   logic             done_m1_r;
   logic             done_m2_r;
   logic             done_tgl_r;
   logic [7:0]       rd_data_r;
   logic             rd_valid_r;
   logic             dqs_r;

   wire              wr_cmd       = cke_i & cmd_mrw_i;
   wire              rd_cmd       = cke_i & cmd_mrr_i;
   wire              is_vendor    = (ma_i >= MA_VENDOR_LO_START && ma_i <= MA_VENDOR_LO_END) ||
                                    (ma_i >= MA_VENDOR_HI_START && ma_i <= MA_VENDOR_HI_END);
   // vendor ranges never reach a register, so the decoders below see them as misses
   wire              wr_ok        = wr_cmd & ~is_vendor;
   wire              wr_reset     = wr_ok & (ma_i == MA_SOFT_RESET_COMMAND);
   wire              wr_feat_one  = wr_ok & (ma_i == MA_DEVICE_FEATURE_ONE);
   wire              wr_feat_two  = wr_ok & (ma_i == MA_DEVICE_FEATURE_TWO);
   wire              wr_io_cfg    = wr_ok & (ma_i == MA_IO_CONFIGURATION);
   wire              wr_bank      = wr_ok & (ma_i == MA_PARTIAL_ARRAY_BANK_MASK);
   wire              wr_zq        = wr_ok & (ma_i == MA_IO_CALIBRATION_COMMAND) &
                                    (op_i == ZQ_INIT_CODE);
   wire              init_busy    = (reset_tgl_r != done_m2_r);
   wire              pending      = (state_r != ST_IDLE);

   // read-only registers, reserved bits forced to zero
   wire [7:0]        info_byte    = {3'h0, selftest_r, 1'b0, 1'b0, pending};
   wire [7:0]        refresh_byte = {1'b0, 4'h0, REFRESH_RATE[2:0]};

   logic [7:0]       rd_mux;
   always_comb begin
      unique case (ma_i)
         MA_DEVICE_INFORMATION:    rd_mux = info_byte;
         MA_REFRESH_RATE_STATUS:   rd_mux = refresh_byte;
         MA_MAKER_IDENTITY:        rd_mux = MAKER_IDENTITY;
         MA_REVISION_ONE:          rd_mux = REVISION_ONE;
         MA_REVISION_TWO:          rd_mux = REVISION_TWO;
         MA_WIDTH_DENSITY_TYPE:    rd_mux = WIDTH_DENSITY;
         MA_CALIBRATION_PATTERN_A: rd_mux = PATTERN_A;
         MA_CALIBRATION_PATTERN_B: rd_mux = PATTERN_B;
         // write-only and reserved addresses: filler byte, strobe still runs
         default:                  rd_mux = UNDEFINED_BYTE;
      endcase
   end

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_POWER_UP:   if (cke_i) state_nxt = ST_WAIT_RESET;
         ST_WAIT_RESET: state_nxt = ST_WAIT_RESET;
         ST_AUTO_INIT:  if (!init_busy) state_nxt = ST_IDLE;
         ST_IDLE:       state_nxt = ST_IDLE;
      endcase
      // a reset write restarts from any state, also outside power-up
      if (wr_reset) state_nxt = ST_AUTO_INIT;
   end

   always_ff @(posedge ck_mem_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_r <= ST_POWER_UP;
      end else begin
         state_r <= state_nxt;
      end
   end

   // read-only addresses have no write decode at all
   always_ff @(posedge ck_mem_i or negedge rstn_i) begin
      if (!rstn_i) begin
         feature_one_r <= FEATURE_ONE_RST;
         feature_two_r <= FEATURE_TWO_RST;
         io_config_r   <= IO_CONFIG_RST;
         bank_mask_r   <= BANK_MASK_RST;
      end else begin
         if (wr_feat_one) feature_one_r <= op_i;
         if (wr_feat_two) feature_two_r <= op_i;
         if (wr_io_cfg)   io_config_r   <= op_i;
         if (wr_bank)     bank_mask_r   <= op_i;
      end
   end

   // self-test result: cleared by reset write, set by calibration command
   always_ff @(posedge ck_mem_i or negedge rstn_i) begin
      if (!rstn_i) begin
         selftest_r <= SELFTEST_NONE;
      end else if (wr_reset) begin
         selftest_r <= SELFTEST_NONE;
      end else if (wr_zq) begin
         selftest_r <= SELFTEST_PASS;
      end
   end

   // read answer one link cycle after the command
   always_ff @(posedge ck_mem_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_data_r  <= ZERO_BYTE;
         rd_valid_r <= 1'b0;
         dqs_r      <= 1'b0;
      end else begin
         rd_valid_r <= rd_cmd;
         dqs_r      <= rd_cmd;
         if (rd_cmd) rd_data_r <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // crossing: reset request by toggle, completion back by toggle

   always_ff @(posedge ck_mem_i or negedge rstn_i) begin
      if (!rstn_i) begin
         reset_tgl_r <= 1'b0;
         done_m1_r   <= 1'b0;
         done_m2_r   <= 1'b0;
      end else begin
         if (wr_reset) reset_tgl_r <= ~reset_tgl_r;
         done_m1_r <= done_tgl_r;
         done_m2_r <= done_m1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // system domain: auto-initialization timer

   logic                  req_m1_r;
   logic                  req_m2_r;
   logic                  req_m3_r;
   logic                  busy_r;
   logic [INIT_CNT_W-1:0] cnt_r;

   wire                   req_edge = req_m2_r ^ req_m3_r;
   // a second reset during the run restarts the count, but the two toggles cancel and the link side goes idle one cycle after it
   wire                   run_end  = busy_r & (cnt_r == INIT_CNT_W'(AUTO_INIT_RUN_CYC - 1));

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         req_m1_r <= 1'b0;
         req_m2_r <= 1'b0;
         req_m3_r <= 1'b0;
      end else begin
         req_m1_r <= reset_tgl_r;
         req_m2_r <= req_m1_r;
         req_m3_r <= req_m2_r;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         busy_r     <= 1'b0;
         cnt_r      <= '0;
         done_tgl_r <= 1'b0;
      end else if (req_edge) begin
         busy_r <= 1'b1;
         cnt_r  <= '0;
      end else if (run_end) begin
         busy_r     <= 1'b0;
         done_tgl_r <= req_m3_r;
      end else if (busy_r) begin
         cnt_r <= cnt_r + INIT_CNT_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs; drivers released whenever clock enable is low

   assign dq_o                = rd_data_r;
   assign dq_oe_o             = rd_valid_r & cke_i;
   assign dqs_o               = dqs_r;
   assign dqs_oe_o            = rd_valid_r & cke_i;
   assign rd_valid_o          = rd_valid_r;
   assign idle_o              = (state_r == ST_IDLE);
   assign auto_init_pending_o = pending;
   assign feature_one_o       = feature_one_r;
   assign feature_two_o       = feature_two_r;
   assign io_config_o         = io_config_r;
   assign bank_mask_o         = bank_mask_r;
   assign state_o             = state_r;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   run_bound_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      busy_r |-> cnt_r < INIT_CNT_W'(AUTO_INIT_MAX_CYC))
      else $error("auto-init count passed its maximum");

   run_length_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      $rose(busy_r) ##1 !req_edge [*8] |-> busy_r)
      else $error("auto-init ended too early");

   drive_off_a: assert property (@(posedge ck_mem_i) disable iff (!rstn_i)
      !cke_i |-> !dq_oe_o && !dqs_oe_o)
      else $error("outputs driven while clock enable low");

   info_zero_a: assert property (@(posedge ck_mem_i) disable iff (!rstn_i)
      rd_cmd && ma_i == MA_DEVICE_INFORMATION |=> rd_valid_o && dq_o[7:5] == 3'h0
      && dq_o[0] == $past(pending))
      else $error("device information read wrong");

   filler_strobe_a: assert property (@(posedge ck_mem_i) disable iff (!rstn_i)
      rd_cmd && ma_i == MA_DEVICE_FEATURE_ONE |=> dqs_o && dq_o == UNDEFINED_BYTE)
      else $error("write-only read lost its strobe");

   read_answer_a: assert property (@(posedge ck_mem_i) disable iff (!rstn_i)
      rd_cmd |=> rd_valid_o && dqs_o && dq_o == $past(rd_mux))
      else $error("read answer missing");

   ro_write_a: assert property (@(posedge ck_mem_i) disable iff (!rstn_i)
      wr_cmd && ma_i == MA_MAKER_IDENTITY |=> $stable(feature_one_r)
      && $stable(state_r) && $stable(selftest_r))
      else $error("read-only write changed the device");

   vendor_write_a: assert property (@(posedge ck_mem_i) disable iff (!rstn_i)
      wr_cmd && is_vendor |=> $stable(state_r) && $stable(bank_mask_r)
      && $stable(reset_tgl_r))
      else $error("vendor address write took effect");

   pattern_a_a: assert property (@(posedge ck_mem_i) disable iff (!rstn_i)
      rd_cmd && ma_i == MA_CALIBRATION_PATTERN_A |=> dq_o == PATTERN_A)
      else $error("first pattern read wrong");

   pattern_b_a: assert property (@(posedge ck_mem_i) disable iff (!rstn_i)
      rd_cmd && ma_i == MA_CALIBRATION_PATTERN_B |=> dq_o == PATTERN_B)
      else $error("second pattern read wrong");

   reset_restart_a: assert property (@(posedge ck_mem_i) disable iff (!rstn_i)
      wr_reset |=> state_r == ST_AUTO_INIT && auto_init_pending_o)
      else $error("reset write did not restart auto-init");

   idle_entry_a: assert property (@(posedge ck_mem_i) disable iff (!rstn_i)
      state_r == ST_AUTO_INIT && !init_busy && !wr_reset |=> idle_o && !auto_init_pending_o)
      else $error("device not idle after auto-init");

   boot_cov: cover property (@(posedge ck_mem_i) disable iff (!rstn_i)
      state_r == ST_AUTO_INIT ##1 state_r == ST_IDLE);
   rewrite_cov: cover property (@(posedge ck_mem_i) disable iff (!rstn_i)
      idle_o && wr_reset);
   zq_cov: cover property (@(posedge ck_mem_i) disable iff (!rstn_i)
      wr_zq ##1 rd_cmd && ma_i == MA_DEVICE_INFORMATION);
   run_cov: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
      run_end);
   gated_cov: cover property (@(posedge ck_mem_i) disable iff (!rstn_i)
      rd_valid_o && !cke_i);

endmodule : lpddr2_init_and_mode_registers

// ==== hw/lpddr2_init_pkg.sv ====
// constants for the mode-register and bring-up block
package lpddr2_init_pkg;

   // mode register addresses
   localparam logic [7:0] MA_DEVICE_INFORMATION      = 8'h00;
   localparam logic [7:0] MA_DEVICE_FEATURE_ONE      = 8'h01;
   localparam logic [7:0] MA_DEVICE_FEATURE_TWO      = 8'h02;
   localparam logic [7:0] MA_IO_CONFIGURATION        = 8'h03;
   localparam logic [7:0] MA_REFRESH_RATE_STATUS     = 8'h04;
   localparam logic [7:0] MA_MAKER_IDENTITY          = 8'h05;
   localparam logic [7:0] MA_REVISION_ONE            = 8'h06;
   localparam logic [7:0] MA_REVISION_TWO            = 8'h07;
   localparam logic [7:0] MA_WIDTH_DENSITY_TYPE      = 8'h08;
   localparam logic [7:0] MA_VENDOR_TEST_CONTROL     = 8'h09;
   localparam logic [7:0] MA_IO_CALIBRATION_COMMAND  = 8'h0A;
   localparam logic [7:0] MA_PARTIAL_ARRAY_BANK_MASK = 8'h10;
   localparam logic [7:0] MA_RESERVED_WRITABLE       = 8'h11;
   localparam logic [7:0] MA_CALIBRATION_PATTERN_A   = 8'h20;
   localparam logic [7:0] MA_CALIBRATION_PATTERN_B   = 8'h28;
   localparam logic [7:0] MA_SOFT_RESET_COMMAND      = 8'h3F;
   localparam logic [7:0] MA_VENDOR_LO_START         = 8'h80;
   localparam logic [7:0] MA_VENDOR_LO_END           = 8'hBE;
   localparam logic [7:0] MA_VENDOR_HI_START         = 8'hC0;
   localparam logic [7:0] MA_VENDOR_HI_END           = 8'hFE;

   // field positions in the device information register
   localparam int POS_AUTO_INIT_PENDING     = 0;
   localparam int POS_DEVICE_KIND_FLAG      = 1;
   localparam int POS_INVALID_DATA_SUPPORT  = 2;
   localparam int POS_RESISTOR_SELFTEST_LO  = 3;

   // reset values of the writable registers
   localparam logic [7:0] FEATURE_ONE_RST   = 8'h22;
   localparam logic [7:0] FEATURE_TWO_RST   = 8'h01;
   localparam logic [7:0] IO_CONFIG_RST     = 8'h02;
   localparam logic [7:0] BANK_MASK_RST     = 8'h00;
   localparam logic [7:0] ZERO_BYTE         = 8'h00;
   localparam logic [1:0] SELFTEST_NONE     = 2'h0;
   localparam logic [1:0] SELFTEST_PASS     = 2'h3;
   localparam logic [7:0] ZQ_INIT_CODE      = 8'hFF;

   // read-only contents; the identity values are arbitrary
   localparam logic [7:0] MAKER_IDENTITY    = 8'h5A;
   localparam logic [7:0] REVISION_ONE      = 8'h01;
   localparam logic [7:0] REVISION_TWO      = 8'h00;
   localparam logic [7:0] WIDTH_DENSITY     = 8'h10;
   localparam logic [7:0] REFRESH_RATE      = 8'h03;
   localparam logic [7:0] PATTERN_A         = 8'h00;
   localparam logic [7:0] PATTERN_B         = 8'hFF;
   localparam logic [7:0] UNDEFINED_BYTE    = 8'hA5;

   // auto-initialization timing on the 250 MHz system clock
   localparam int CLK_SYS_PERIOD_PS        = 4000;
   localparam int AUTO_INIT_MAX_TIME_US    = 10;
   localparam int AUTO_INIT_MAX_CYC        = (AUTO_INIT_MAX_TIME_US * 1000000) / CLK_SYS_PERIOD_PS;
   localparam int AUTO_INIT_RUN_TIME_US    = 8;
   localparam int AUTO_INIT_RUN_CYC        = (AUTO_INIT_RUN_TIME_US * 1000000) / CLK_SYS_PERIOD_PS;
   localparam int INIT_CNT_W               = 12;

   typedef enum logic [1:0] {
      ST_POWER_UP   = 2'b00,
      ST_WAIT_RESET = 2'b01,
      ST_AUTO_INIT  = 2'b10,
      ST_IDLE       = 2'b11
   } dev_state_t;

endpackage : lpddr2_init_pkg

// ==== sim/lpddr2_ctrl_model.sv ====
// controller-side model: link clock, clock enable and mode register commands
module lpddr2_ctrl_model #(
   parameter int IDLE_NS = 200000
) (
   output logic       ck_mem_o,
   output logic       cke_o,
   output logic       cmd_mrw_o,
   output logic       cmd_mrr_o,
   output logic [7:0] ma_o,
   output logic [7:0] op_o
);
   timeunit 1ns;
   timeprecision 1ps;

   localparam int CK_NS = 48; // inside 18..100 ns so boot reads are legal

   initial begin
      ck_mem_o = 1'b0;
      cke_o = 1'b0; // low from power-up on
      cmd_mrw_o = 1'b0;
      cmd_mrr_o = 1'b0;
      ma_o = 8'h00;
      op_o = 8'h00;
      #7;
      forever #(CK_NS / 2) ck_mem_o = ~ck_mem_o; // free running, never retimed
   end

   ////////////////////////////////////////////////////////////////////////////
   // waits are whole link cycles, rounded up so no interval comes out short
   task automatic wait_ns(input int ns);
      repeat ((ns + CK_NS - 1) / CK_NS) @(negedge ck_mem_o);
   endtask : wait_ns

   task automatic power_up();
      cke_o = 1'b0;
      wait_ns(100);
      repeat (5) @(negedge ck_mem_o);
      cke_o = 1'b1;
      wait_ns(IDLE_NS); // only no-ops meanwhile
   endtask : power_up

   // one command, held over the taking edge; then both command lines go low and address and data show the inverse
   task automatic send(input logic wr, input logic [7:0] ma, input logic [7:0] op);
      @(negedge ck_mem_o);
      cmd_mrw_o = wr;
      cmd_mrr_o = ~wr;
      ma_o = ma;
      op_o = op;
      @(negedge ck_mem_o);
      cmd_mrw_o = 1'b0;
      cmd_mrr_o = 1'b0;
      ma_o = ~ma;
      op_o = ~op;
   endtask : send
endmodule : lpddr2_ctrl_model

// ==== sim/lpddr2_init_and_mode_registers_bench.sv ====
// self-checking bench for the bring-up and mode register block
module lpddr2_init_and_mode_registers_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import lpddr2_init_pkg::*;

   logic       clk_sys_i, rstn_i, ck_mem_i, cke_i, cmd_mrw_i, cmd_mrr_i;
   logic [7:0] ma_i, op_i, dq_o, feature_one_o, feature_two_o, io_config_o, bank_mask_o;
   logic       dq_oe_o, dqs_o, dqs_oe_o, rd_valid_o, idle_o, auto_init_pending_o;
   dev_state_t state_o;
   int         num_errors, compares, ref_mr [256], ref_out [4];
   int         cfg_ma [4] = '{1, 2, 3, 'h10};
   int         cfg_mask [4] = '{'hFF, 'h0F, 'h0F, 'hFF};
   int         ro_q [$] = '{0, 4, 5, 6, 7, 8, 'h20, 'h28};
   int         rsv_q [$] = '{'h0B, 'h12, 'h3E, 'h7F, 'h80, 'hBE, 'hC0, 'hFE};
   int unsigned seed = 33644;
   realtime    t0;

   lpddr2_init_and_mode_registers u_lpddr2_init_and_mode_registers (.*);
   lpddr2_ctrl_model #(.IDLE_NS(200000)) u_lpddr2_ctrl_model (
      .ck_mem_o(ck_mem_i), .cke_o(cke_i), .cmd_mrw_o(cmd_mrw_i), .cmd_mrr_o(cmd_mrr_i),
      .ma_o(ma_i), .op_o(op_i));

   initial clk_sys_i = 1'b0;
   always #2 clk_sys_i = ~clk_sys_i;

   ////////////////////////////////////////////////////////////////////////////
   function automatic int rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return int'(seed[7:0]);
   endfunction : rnd

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_of_test

   // read answer is registered on the taking edge and checked half a link cycle later
   task automatic rd(input int ma);
      u_lpddr2_ctrl_model.send(1'b0, 8'(ma), 8'h00);
      check({rd_valid_o, dqs_o, dq_oe_o, dqs_oe_o, 4'h0}, cke_i === 1'b1 ? 8'hF0 : 8'h00);
      if (cke_i === 1'b1)
         check(dq_o, 8'(ref_mr[ma]));
   endtask : rd

   task automatic wr(input int ma, input int op);
      u_lpddr2_ctrl_model.send(1'b1, 8'(ma), 8'(op));
      if (cke_i === 1'b1) begin
         foreach (cfg_ma[i]) if (cfg_ma[i] == ma) ref_out[i] = op;
         if (ma == 'h0A && op == ZQ_INIT_CODE) ref_mr[0] = ref_mr[0] | 'h18;
         if (ma == 'h3F) ref_mr[0] = 'h01;
      end
      check(feature_one_o, 8'(ref_out[0]));
      check(feature_two_o, 8'(ref_out[1]));
      check(io_config_o, 8'(ref_out[2]));
      check(bank_mask_o, 8'(ref_out[3]));
   endtask : wr

   // soft reset, then poll until auto-init reports done
   task automatic reinit();
      t0 = $realtime;
      wr('h3F, 0);
      u_lpddr2_ctrl_model.wait_ns(1000);
      check({6'h0, state_o}, {6'h0, ST_AUTO_INIT});
      rd(0);
      for (int n = 0; n < 3000 && idle_o !== 1'b1; n++) @(negedge clk_sys_i);
      check({7'h0, ($realtime - t0) <= 10048.0}, 8'h01);
      check({6'h0, state_o}, {6'h0, ST_IDLE});
      check({7'h0, auto_init_pending_o}, 8'h00);
      ref_mr[0] = ref_mr[0] & 'hFE;
      rd(0);
   endtask : reinit

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rstn_i = 1'b0;
      foreach (ref_mr[i]) ref_mr[i] = UNDEFINED_BYTE;
      ref_mr[0] = 'h01;
      ref_mr[4] = REFRESH_RATE;
      ref_mr[5] = MAKER_IDENTITY;
      ref_mr[6] = REVISION_ONE;
      ref_mr[7] = REVISION_TWO;
      ref_mr[8] = WIDTH_DENSITY;
      ref_mr['h20] = PATTERN_A;
      ref_mr['h28] = PATTERN_B;
      ref_out = '{FEATURE_ONE_RST, FEATURE_TWO_RST, IO_CONFIG_RST, BANK_MASK_RST};
      repeat (16) @(negedge clk_sys_i);
      rstn_i = 1'b1;
      @(negedge clk_sys_i);
      check({6'h0, state_o}, {6'h0, ST_POWER_UP});
      check({idle_o, auto_init_pending_o, 6'h0}, 8'h40);
      check({dq_oe_o, dqs_oe_o, 6'h0}, 8'h00);
      $display("test reset done");
      u_lpddr2_ctrl_model.power_up();
      check({6'h0, state_o}, {6'h0, ST_WAIT_RESET});
      reinit();
      $display("test power-up init done");
      wr('h0A, ZQ_INIT_CODE);
      u_lpddr2_ctrl_model.wait_ns(1000);
      rd(0);
      $display("test calibration done");
      // reserved bits written as zero by the controller side
      foreach (cfg_ma[i]) wr(cfg_ma[i], rnd() & cfg_mask[i]);
      foreach (cfg_ma[i]) rd(cfg_ma[i]);
      // reserved addresses are only ever read, never written
      foreach (rsv_q[i]) rd(rsv_q[i]);
      rd('h09);
      $display("test configuration done");
      foreach (ro_q[i]) begin
         wr(ro_q[i], rnd());
         rd(ro_q[i]);
      end
      $display("test read-only done");
      // clock enable dropped while an answer stands: drivers let go at once
      u_lpddr2_ctrl_model.send(1'b0, 8'h20, 8'h00);
      u_lpddr2_ctrl_model.cke_o = 1'b0;
      #1;
      check({rd_valid_o, dqs_o, dq_oe_o, dqs_oe_o, 4'h0}, 8'hC0);
      check(dq_o, PATTERN_A);
      rd('h20);
      wr(1, rnd());
      @(negedge ck_mem_i);
      u_lpddr2_ctrl_model.cke_o = 1'b1;
      rd('h28);
      $display("test clock enable low done");
      reinit();
      $display("test re-initialization done");
      end_of_test();
   end

   // whole run is near 225 us; this limit only trips on a hang
   initial begin
      #300000;
      num_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule : lpddr2_init_and_mode_registers_bench
